// ===== oled_port_pkg.sv
/*
 Shared constants for both ends of the parallel host port: timing, command
 codes, memory geometry and bus mode codes.
 Assumes one 25 MHz clock on both ends.
*/
package oled_port_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_NS = 40;
	localparam int T_LOGIC_MS = 1;
	localparam int T_RES_US = 2;
	localparam int T_VCC_US = 2;
	localparam int T_VCC_SETTLE_US = 100;
	localparam int T_WAKE_MS = 200;
	localparam int T_OFF_MIN_MS = 80;
	localparam int T_OFF_MS = 100;
	localparam int T_CYCLE_NS = 300;
	localparam int T_STRB_NS = 150;
	localparam int LOGIC_CYC = (T_LOGIC_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int RES_CYC = (T_RES_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int VCC_CYC = (T_VCC_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int VCC_SETTLE_CYC = (T_VCC_SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int WAKE_CYC = (T_WAKE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int OFF_CYC = (T_OFF_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	localparam int XFER_CYC = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int STRB_CYC = (T_STRB_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 23;
	localparam int RES_W = 6;
	localparam int PH_W = 3;

	// ==========================================================
	// Commands and status
	localparam logic [7:0] CMD_SLEEP_OUT = 8'h11;
	localparam logic [7:0] CMD_DISPLAY_OFF = 8'hAE;
	localparam logic [7:0] CMD_REMAP = 8'hA0;
	localparam int REMAP_COL_BIT = 0;
	localparam int REMAP_ROW_BIT = 1;
	localparam int ST_DRV_BIT = 7;
	localparam int ST_SLEEP_BIT = 6;

	// ==========================================================
	// Memory geometry
	localparam int ADDR_W = 7;
	localparam int COMP_W = 6;
	localparam int PIX_W = 3 * COMP_W;
	localparam int RAM_WORDS = 128 * 128;
	localparam logic [ADDR_W-1:0] ADDR_LAST = 7'h7F;
	localparam logic [1:0] BYTE_LAST = 2'h2;

	// ==========================================================
	// Bus modes and host queue
	localparam logic MODE_INTEL = 1'b0;
	localparam logic MODE_MOTO = 1'b1;
	localparam int FIFO_W = 9;
	localparam int FIFO_DEPTH = 8;
endpackage

// ===== oled_bus_if.sv
/*
 Pin bundle between host end and device end of the parallel port.
 Assumes at most one side enables its byte driver at a time.
*/
`timescale 1ns/10ps
interface oled_bus_if;
	logic cs_n;
	logic cmd_data_sel;
	logic wr_dir_pin;
	logic strb_pin;
	logic res_n_pin;
	logic panel_supply_on;
	logic bus_mode;
	logic [7:0] host_db_o;
	logic host_db_oe;
	logic [7:0] dev_db_o;
	logic dev_db_oe;
	logic [7:0] parallel_byte_bus;

	// Resolved bus level; undriven bus reads as zero
	assign parallel_byte_bus = host_db_oe ? host_db_o : (dev_db_oe ? dev_db_o : 8'h00);

	modport host (output cs_n, output cmd_data_sel, output wr_dir_pin, output strb_pin,
		output res_n_pin, output panel_supply_on, output bus_mode, output host_db_o,
		output host_db_oe, input parallel_byte_bus);
	modport device (input cs_n, input cmd_data_sel, input wr_dir_pin, input strb_pin,
		input res_n_pin, input panel_supply_on, input bus_mode, output dev_db_o,
		output dev_db_oe, input parallel_byte_bus);
endinterface

// ===== byte_fifo.sv
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes a single clock; pop and push may happen in the same cycle.
*/
`timescale 1ns/10ps
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wptr;
		logic [AW:0] rptr;
		logic full;
		logic empty;
	} fifo_s;

	fifo_s st_reg;
	fifo_s st_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full;
	logic empty;
	logic push;
	logic pop;

	// Flags are registered so that in_ready leaves the host end from a flop
	assign full = st_reg.full;
	assign empty = st_reg.empty;
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[st_reg.rptr[AW-1:0]];
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.wptr = st_reg.wptr + 1'b1;
		end
		if (pop) begin
			st_next.rptr = st_reg.rptr + 1'b1;
		end
		st_next.full = (st_next.wptr[AW] != st_next.rptr[AW]) &&
			(st_next.wptr[AW-1:0] == st_next.rptr[AW-1:0]);
		st_next.empty = st_next.wptr == st_next.rptr;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{empty: 1'b1, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[st_reg.wptr[AW-1:0]] <= in_data;
		end
	end
endmodule

// ===== oled_device_end.sv
/*
 Device end of the parallel port: bus decode in both modes, reset pin,
 sleep and display-off handling, pixel memory and remapped scan-out.
 Assumes pins synchronous to mclk and a host that paces transfers.
*/
`timescale 1ns/10ps
module oled_device_end #(
	parameter int WAKE_CYCLES = oled_port_pkg::WAKE_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	oled_bus_if.device bus,
	output logic row_drivers_on,
	output logic column_drivers_on,
	output logic [6:0] scan_row,
	output logic [6:0] scan_col,
	output logic [17:0] scan_pixel
);
	// ==========================================================
	// State
	typedef struct packed {
		logic prev_wr;
		logic prev_strb;
		logic [oled_port_pkg::RES_W-1:0] res_cnt;
		logic sleeping;
		logic drv_on;
		logic waking;
		logic [oled_port_pkg::TMR_W-1:0] wake_cnt;
		logic [1:0] remap;
		logic remap_pend;
		logic [1:0] byte_idx;
		logic [11:0] ab;
		logic [6:0] wr_col;
		logic [6:0] wr_row;
		logic we;
		logic [13:0] we_addr;
		logic [17:0] we_data;
		logic [7:0] dout;
		logic doe;
		logic [6:0] sc_col;
		logic [6:0] sc_row;
		logic [6:0] out_col;
		logic [6:0] out_row;
	} dev_s;

	dev_s st_reg;
	dev_s st_next;
	logic [17:0] ram [oled_port_pkg::RAM_WORDS];
	logic [17:0] pix_reg;
	logic moto;
	logic wr_ev;
	logic rd_act;
	logic [7:0] db;
	logic [13:0] scan_addr;

	assign moto = bus.bus_mode == oled_port_pkg::MODE_MOTO;
	assign db = bus.parallel_byte_bus;
	// Write taken on strobe release: WR rising in Intel mode, E falling in Motorola
	always_comb begin
		if (moto) begin
			wr_ev = !bus.cs_n && st_reg.prev_strb && !bus.strb_pin && !bus.wr_dir_pin;
			rd_act = !bus.cs_n && bus.strb_pin && bus.wr_dir_pin;
		end else begin
			wr_ev = !bus.cs_n && !st_reg.prev_wr && bus.wr_dir_pin;
			rd_act = !bus.cs_n && !bus.strb_pin;
		end
	end
	// Mirror of a 7-bit index is its complement, so 0 maps to 127
	assign scan_addr = {st_reg.sc_row ^ {7{st_reg.remap[oled_port_pkg::REMAP_ROW_BIT]}},
		st_reg.sc_col ^ {7{st_reg.remap[oled_port_pkg::REMAP_COL_BIT]}}};

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.prev_wr = bus.wr_dir_pin;
		st_next.prev_strb = bus.strb_pin;
		st_next.we = 1'b0;
		st_next.out_col = st_reg.sc_col;
		st_next.out_row = st_reg.sc_row;
		st_next.sc_col = st_reg.sc_col + 7'h01;
		if (st_reg.sc_col == oled_port_pkg::ADDR_LAST) begin
			st_next.sc_row = st_reg.sc_row + 7'h01;
		end
		if (st_reg.waking) begin
			if (st_reg.wake_cnt == oled_port_pkg::TMR_W'(WAKE_CYCLES - 1)) begin
				st_next.waking = 1'b0;
				st_next.drv_on = 1'b1;
			end else begin
				st_next.wake_cnt = st_reg.wake_cnt + 1'b1;
			end
		end
		st_next.doe = rd_act && bus.res_n_pin;
		st_next.dout = 8'h00;
		st_next.dout[oled_port_pkg::ST_DRV_BIT] = st_reg.drv_on;
		st_next.dout[oled_port_pkg::ST_SLEEP_BIT] = st_reg.sleeping;
		st_next.dout[1:0] = st_reg.remap;
		if (!bus.res_n_pin) begin
			st_next.doe = 1'b0;
			// Defaults apply on the low sample that completes the minimum width
			if (st_reg.res_cnt != oled_port_pkg::RES_W'(oled_port_pkg::RES_CYC - 1)) begin
				st_next.res_cnt = st_reg.res_cnt + 1'b1;
			end else begin
				st_next.sleeping = 1'b1;
				st_next.drv_on = 1'b0;
				st_next.waking = 1'b0;
				st_next.remap = 2'h0;
				st_next.remap_pend = 1'b0;
				st_next.byte_idx = 2'h0;
				st_next.wr_col = 7'h00;
				st_next.wr_row = 7'h00;
			end
		end else begin
			st_next.res_cnt = '0;
			if (wr_ev && !bus.cmd_data_sel) begin
				st_next.remap_pend = 1'b0;
				st_next.byte_idx = 2'h0;
				unique case (db)
					oled_port_pkg::CMD_SLEEP_OUT: begin
						st_next.sleeping = 1'b0;
						st_next.waking = 1'b1;
						st_next.wake_cnt = '0;
					end
					oled_port_pkg::CMD_DISPLAY_OFF: begin
						st_next.sleeping = 1'b1;
						st_next.waking = 1'b0;
						st_next.drv_on = 1'b0;
					end
					oled_port_pkg::CMD_REMAP: st_next.remap_pend = 1'b1;
					default: st_next.remap_pend = 1'b0;
				endcase
			end else if (wr_ev && st_reg.remap_pend) begin
				st_next.remap = db[1:0];
				st_next.remap_pend = 1'b0;
			end else if (wr_ev) begin
				// Three data bytes, low six bits each, make components A, B, C
				if (st_reg.byte_idx == oled_port_pkg::BYTE_LAST) begin
					st_next.byte_idx = 2'h0;
					st_next.we = 1'b1;
					st_next.we_addr = {st_reg.wr_row, st_reg.wr_col};
					st_next.we_data = {st_reg.ab, db[5:0]};
					st_next.wr_col = st_reg.wr_col + 7'h01;
					if (st_reg.wr_col == oled_port_pkg::ADDR_LAST) begin
						st_next.wr_row = st_reg.wr_row + 7'h01;
					end
				end else begin
					st_next.byte_idx = st_reg.byte_idx + 2'h1;
					st_next.ab = {st_reg.ab[5:0], db[5:0]};
				end
			end
		end
	end

	// ==========================================================
	// Registers and pixel memory
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{prev_wr: 1'b1, sleeping: 1'b1, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (st_reg.we) begin
			ram[st_reg.we_addr] <= st_reg.we_data;
		end
		pix_reg <= ram[scan_addr];
	end

	assign bus.dev_db_o = st_reg.dout;
	assign bus.dev_db_oe = st_reg.doe;
	assign row_drivers_on = st_reg.drv_on;
	assign column_drivers_on = st_reg.drv_on;
	assign scan_row = st_reg.out_row;
	assign scan_col = st_reg.out_col;
	assign scan_pixel = pix_reg;
endmodule

// ===== oled_host_end.sv
/*
 Host end of the parallel port: power sequencing, reset pin, panel supply,
 byte transfers in either bus mode and a queue of outgoing bytes.
 Assumes the bus mode input is steady while powered.
*/
`timescale 1ns/10ps
// What this block does
// - D/C high for data, low for command
// - Write strobe or read/write select per mode
// - Read strobe or enable strobe per mode
// - Host switches panel supply on and off
// - Wait 1 ms after logic supply
// - Hold reset low 2 us, then release
// - Panel supply on 2 us after reset
// - Send 11h; drivers on 200 ms later
// - Send AEh before panel supply off
// - Wait 100 ms before logic supply off
// - Logic supply never off while panel on
// - Reset pulse restores device defaults
// - Pixel memory 128 by 128 by 18
// - Pixel is three 6-bit components
// - Device scan-out reverses row and column mapping
module oled_host_end #(
	parameter int LOGIC_CYCLES = oled_port_pkg::LOGIC_CYC,
	parameter int OFF_CYCLES = oled_port_pkg::OFF_CYC
) (
	input wire logic mclk,
	input wire logic rstn,
	oled_bus_if.host bus,
	input wire logic mode_sel,
	input wire logic power_up_req,
	input wire logic power_down_req,
	input wire logic in_valid,
	input wire logic in_is_data,
	input wire logic [7:0] in_byte,
	output logic in_ready,
	input wire logic rd_req,
	output logic rd_valid,
	output logic [7:0] rd_byte,
	output logic logic_supply_on,
	output logic link_ready
);
	// ==========================================================
	// State
	typedef enum logic [7:0] {
		S_OFF = 8'h01,
		S_LOGIC_WAIT = 8'h02,
		S_RES_LOW = 8'h04,
		S_VCC_SETTLE = 8'h08,
		S_WAKE = 8'h10,
		S_RUN = 8'h20,
		S_DISP_OFF = 8'h40,
		S_OFF_WAIT = 8'h80
	} pwr_e;

	typedef struct packed {
		pwr_e pwr;
		logic [oled_port_pkg::TMR_W-1:0] tmr;
		logic busy;
		logic [oled_port_pkg::PH_W-1:0] phase;
		logic rd;
		logic mode;
		logic cs_n;
		logic dc;
		logic wr;
		logic strb;
		logic res_n;
		logic vcc;
		logic vdd;
		logic [7:0] dout;
		logic doe;
		logic rd_valid;
		logic [7:0] rd_byte;
		logic ready;
	} host_s;

	host_s st_reg;
	host_s st_next;
	logic q_valid;
	logic [8:0] q_data;
	logic q_pop;
	logic idle;

	byte_fifo #(
		.WIDTH(oled_port_pkg::FIFO_W),
		.DEPTH(oled_port_pkg::FIFO_DEPTH)
	) queue (
		.mclk(mclk),
		.rstn(rstn),
		.in_valid(in_valid),
		.in_data({in_is_data, in_byte}),
		.in_ready(in_ready),
		.out_valid(q_valid),
		.out_data(q_data),
		.out_ready(q_pop)
	);

	assign idle = !st_reg.busy;
	// Power-down wins the idle slot, so no queued byte is popped and lost
	assign q_pop = st_reg.pwr == S_RUN && idle && !rd_req && !power_down_req && q_valid;

	// ==========================================================
	// Transfer start
	function automatic host_s start_xfer(input host_s s, input logic rd, input logic dc,
		input logic [7:0] b);
		host_s r;
		r = s;
		r.busy = 1'b1;
		r.phase = '0;
		r.rd = rd;
		r.cs_n = 1'b0;
		r.dc = dc;
		r.dout = b;
		r.doe = !rd;
		// Motorola direction set up before enable; Intel strobes stay idle
		r.wr = (s.mode == oled_port_pkg::MODE_MOTO) ? rd : 1'b1;
		return r;
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.rd_valid = 1'b0;
		st_next.tmr = st_reg.tmr + 1'b1;
		if (st_reg.busy) begin
			st_next.phase = st_reg.phase + 1'b1;
			if (st_reg.phase == oled_port_pkg::PH_W'(oled_port_pkg::XFER_CYC - 1)) begin
				st_next.busy = 1'b0;
				st_next.cs_n = 1'b1;
				st_next.doe = 1'b0;
				st_next.wr = 1'b1;
			end else if (st_next.phase <= oled_port_pkg::PH_W'(oled_port_pkg::STRB_CYC)) begin
				if (st_reg.mode == oled_port_pkg::MODE_MOTO) begin
					st_next.strb = 1'b1;
				end else if (st_reg.rd) begin
					st_next.strb = 1'b0;
				end else begin
					st_next.wr = 1'b0;
				end
			end else begin
				st_next.strb = st_reg.mode == oled_port_pkg::MODE_INTEL;
				st_next.wr = (st_reg.mode == oled_port_pkg::MODE_MOTO) ? st_reg.rd : 1'b1;
			end
			if (st_reg.rd && st_reg.phase == oled_port_pkg::PH_W'(oled_port_pkg::STRB_CYC)) begin
				st_next.rd_valid = 1'b1;
				st_next.rd_byte = bus.parallel_byte_bus;
			end
		end
		unique case (st_reg.pwr)
			S_OFF: begin
				st_next.mode = mode_sel;
				st_next.strb = mode_sel == oled_port_pkg::MODE_INTEL;
				st_next.vcc = 1'b0;
				if (power_up_req) begin
					st_next.vdd = 1'b1;
					st_next.tmr = '0;
					st_next.pwr = S_LOGIC_WAIT;
				end
			end
			S_LOGIC_WAIT: begin
				if (st_reg.tmr == oled_port_pkg::TMR_W'(LOGIC_CYCLES - 1)) begin
					st_next.res_n = 1'b0;
					st_next.tmr = '0;
					st_next.pwr = S_RES_LOW;
				end
			end
			S_RES_LOW: begin
				// Reset hold and supply delay share one count; it ends at the reset count and never ends if the supply delay is larger
				if (st_reg.tmr == oled_port_pkg::TMR_W'(oled_port_pkg::RES_CYC - 1) &&
					oled_port_pkg::RES_CYC >= oled_port_pkg::VCC_CYC) begin
					st_next.res_n = 1'b1;
					st_next.vcc = 1'b1;
					st_next.tmr = '0;
					st_next.pwr = S_VCC_SETTLE;
				end
			end
			S_VCC_SETTLE: begin
				if (st_reg.tmr == oled_port_pkg::TMR_W'(oled_port_pkg::VCC_SETTLE_CYC - 1)) begin
					st_next.pwr = S_WAKE;
				end
			end
			S_WAKE: begin
				st_next = start_xfer(st_next, 1'b0, 1'b0, oled_port_pkg::CMD_SLEEP_OUT);
				st_next.ready = 1'b1;
				st_next.pwr = S_RUN;
			end
			S_RUN: begin
				if (idle && power_down_req) begin
					st_next = start_xfer(st_next, 1'b0, 1'b0, oled_port_pkg::CMD_DISPLAY_OFF);
					st_next.ready = 1'b0;
					st_next.pwr = S_DISP_OFF;
				end else if (idle && rd_req) begin
					st_next = start_xfer(st_next, 1'b1, 1'b1, 8'h00);
				end else if (q_pop) begin
					st_next = start_xfer(st_next, 1'b0, q_data[8], q_data[7:0]);
				end
			end
			S_DISP_OFF: begin
				if (idle) begin
					st_next.vcc = 1'b0;
					st_next.tmr = '0;
					st_next.pwr = S_OFF_WAIT;
				end
			end
			S_OFF_WAIT: begin
				if (st_reg.tmr == oled_port_pkg::TMR_W'(OFF_CYCLES - 1)) begin
					st_next.vdd = 1'b0;
					st_next.pwr = S_OFF;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{pwr: S_OFF, cs_n: 1'b1, wr: 1'b1, strb: 1'b1, res_n: 1'b1,
				default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// Outputs
	assign bus.cs_n = st_reg.cs_n;
	assign bus.cmd_data_sel = st_reg.dc;
	assign bus.wr_dir_pin = st_reg.wr;
	assign bus.strb_pin = st_reg.strb;
	assign bus.res_n_pin = st_reg.res_n;
	assign bus.panel_supply_on = st_reg.vcc;
	assign bus.bus_mode = st_reg.mode;
	assign bus.host_db_o = st_reg.dout;
	assign bus.host_db_oe = st_reg.doe;
	assign rd_valid = st_reg.rd_valid;
	assign rd_byte = st_reg.rd_byte;
	assign logic_supply_on = st_reg.vdd;
	assign link_ready = st_reg.ready;
endmodule

// ===== oled_port_properties.sv
/*
 Checker for the pins between host end and device end of the parallel port.
 Assumes it is instantiated beside the interface, fed the interface signals.
*/
`timescale 1ns/10ps
module oled_port_properties (
	input logic mclk,
	input logic rstn,
	input logic cs_n,
	input logic cmd_data_sel,
	input logic wr_dir_pin,
	input logic strb_pin,
	input logic res_n_pin,
	input logic panel_supply_on,
	input logic bus_mode,
	input logic host_db_oe,
	input logic dev_db_oe,
	input logic [7:0] parallel_byte_bus
);
	logic [7:0] low_cnt_reg;
	logic aeh_seen_reg;
	logic strobe_on;
	logic cmd_on_bus;

	// ==========================================================
	// Helper logic
	assign strobe_on = bus_mode ? strb_pin : !(wr_dir_pin && strb_pin);
	assign cmd_on_bus = !cs_n && !cmd_data_sel && host_db_oe;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			low_cnt_reg <= 8'h00;
			aeh_seen_reg <= 1'b0;
		end else begin
			low_cnt_reg <= res_n_pin ? 8'h00 : low_cnt_reg + ((low_cnt_reg != 8'hFF) ? 8'h01 : 8'h00);
			if (cmd_on_bus && parallel_byte_bus == oled_port_pkg::CMD_DISPLAY_OFF) begin
				aeh_seen_reg <= 1'b1;
			end else if (cmd_on_bus && parallel_byte_bus == oled_port_pkg::CMD_SLEEP_OUT) begin
				aeh_seen_reg <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	// ==========================================================
	// Assertions
	a_cs_frame_len: assert property ($fell(cs_n) |-> !cs_n [*8] ##1 cs_n)
		else $error("chip select frame length wrong");
	a_strobe_window: assert property ($fell(cs_n) |-> !strobe_on ##1
		strobe_on [*4] ##1 !strobe_on [*3])
		else $error("strobe phases wrong");
	a_strobe_needs_cs: assert property (strobe_on |-> !cs_n)
		else $error("strobe outside chip select");
	a_dc_steady: assert property (!cs_n && !$fell(cs_n) |->
		$stable(cmd_data_sel) && (!bus_mode || $stable(wr_dir_pin)))
		else $error("select lines moved in frame");
	a_data_steady: assert property (host_db_oe && $past(host_db_oe) |->
		$stable(parallel_byte_bus))
		else $error("write byte moved in frame");
	a_one_driver: assert property (!(host_db_oe && dev_db_oe))
		else $error("both ends drive the byte bus");
	a_read_drive: assert property ($rose(dev_db_oe) |->
		!cs_n && $past(strobe_on) && (bus_mode ? wr_dir_pin : !strb_pin))
		else $error("device drove without a read");
	a_reset_width: assert property ($rose(res_n_pin) |->
		low_cnt_reg >= oled_port_pkg::RES_CYC)
		else $error("reset pulse too short");
	a_panel_after_res: assert property ($rose(panel_supply_on) |->
		low_cnt_reg >= oled_port_pkg::VCC_CYC)
		else $error("panel supply too early");
	a_wake_needs_panel: assert property (cmd_on_bus &&
		parallel_byte_bus == oled_port_pkg::CMD_SLEEP_OUT |-> panel_supply_on)
		else $error("wake command before panel supply");
	a_panel_off_order: assert property ($fell(panel_supply_on) |-> aeh_seen_reg)
		else $error("panel off before display off");

	c_read: cover property ($rose(dev_db_oe));
	c_moto_frame: cover property ($fell(cs_n) && bus_mode);
	c_panel_off: cover property ($fell(panel_supply_on));
endmodule

// ===== tb_oled_parallel_host_port.sv
/*
 Testbench joining host end and device end through the pin interface.
 Assumes shortened power counts set by the parameters below.
*/
`timescale 1ns/10ps
module tb_oled_parallel_host_port;
	localparam int WAKE = 40;
	localparam int OFF = 30;
	logic mclk, rstn, mode_sel, power_up_req, power_down_req, in_valid, in_is_data;
	logic [7:0] in_byte;
	logic in_ready, rd_req, rd_valid, logic_supply_on, link_ready;
	logic [7:0] rd_byte;
	logic row_drivers_on, column_drivers_on;
	logic [6:0] scan_row, scan_col;
	logic [17:0] scan_pixel;
	int err_count = 0;
	int tests_run = 0;
	int refused = 0;
	int cycles = 0;

	oled_bus_if i_oled_bus_if ();
	oled_host_end #(.LOGIC_CYCLES(20), .OFF_CYCLES(OFF)) i_oled_host_end (.mclk(mclk),
		.rstn(rstn), .bus(i_oled_bus_if), .mode_sel(mode_sel), .power_up_req(power_up_req),
		.power_down_req(power_down_req), .in_valid(in_valid), .in_is_data(in_is_data),
		.in_byte(in_byte), .in_ready(in_ready), .rd_req(rd_req), .rd_valid(rd_valid),
		.rd_byte(rd_byte), .logic_supply_on(logic_supply_on), .link_ready(link_ready));
	oled_device_end #(.WAKE_CYCLES(WAKE)) i_oled_device_end (.mclk(mclk), .rstn(rstn),
		.bus(i_oled_bus_if), .row_drivers_on(row_drivers_on),
		.column_drivers_on(column_drivers_on), .scan_row(scan_row), .scan_col(scan_col),
		.scan_pixel(scan_pixel));
	oled_port_properties i_oled_port_properties (.mclk(mclk), .rstn(rstn),
		.cs_n(i_oled_bus_if.cs_n), .cmd_data_sel(i_oled_bus_if.cmd_data_sel),
		.wr_dir_pin(i_oled_bus_if.wr_dir_pin), .strb_pin(i_oled_bus_if.strb_pin),
		.res_n_pin(i_oled_bus_if.res_n_pin), .panel_supply_on(i_oled_bus_if.panel_supply_on),
		.bus_mode(i_oled_bus_if.bus_mode), .host_db_oe(i_oled_bus_if.host_db_oe),
		.dev_db_oe(i_oled_bus_if.dev_db_oe), .parallel_byte_bus(i_oled_bus_if.parallel_byte_bus));

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic push(input logic is_data, input logic [7:0] b);
		in_valid = 1'b1;
		in_is_data = is_data;
		in_byte = b;
		do begin
			@(posedge mclk);
			if (in_ready !== 1'b1) refused++;
		end while (in_ready !== 1'b1);
		#1;
	endtask

	task automatic wait_xfers(input int k);
		int n;
		logic was;
		n = 0;
		was = 1'b1;
		while (k > 0 && n < 2000) begin
			@(posedge mclk);
			n++;
			if (i_oled_bus_if.cs_n === 1'b1 && was === 1'b0) k--;
			was = i_oled_bus_if.cs_n;
		end
		chk(k == 0, 1);
		#1;
	endtask

	task automatic read_status(input logic [7:0] exp);
		int n;
		n = 0;
		rd_req = 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (rd_valid !== 1'b1 && n < 200);
		chk(rd_byte, exp);
		#1;
		rd_req = 1'b0;
	endtask

	task automatic wait_scan(input logic [6:0] r, input logic [6:0] c, input logic [17:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while ((scan_row !== r || scan_col !== c) && n < 20000);
		chk(scan_pixel, exp);
		#1;
	endtask

	// ==========================================================
	// Scenarios
	task automatic power_up(input logic m);
		int n;
		n = 0;
		mode_sel = m;
		power_up_req = 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (link_ready !== 1'b1 && n < 5000);
		#1;
		power_up_req = 1'b0;
		chk(logic_supply_on & i_oled_bus_if.panel_supply_on, 1);
		chk(i_oled_bus_if.bus_mode, m);
		chk(row_drivers_on, 0);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (row_drivers_on !== 1'b1 && n < 500);
		chk(column_drivers_on, 1);
		chk(n > WAKE - 12 && n < WAKE + 20, 1);
		#1;
		read_status(8'h80);
		$display("test power_up done");
	endtask

	task automatic write_pixels();
		push(1'b1, 8'h15);
		push(1'b1, 8'h2A);
		push(1'b1, 8'h3F);
		push(1'b1, 8'hC1);
		push(1'b1, 8'h02);
		push(1'b1, 8'h03);
		in_valid = 1'b0;
		wait_xfers(6);
		wait_scan(7'h00, 7'h00, {6'h15, 6'h2A, 6'h3F});
		wait_scan(7'h00, 7'h01, {6'h01, 6'h02, 6'h03});
		$display("test write_pixels done");
	endtask

	task automatic remap();
		push(1'b0, oled_port_pkg::CMD_REMAP);
		push(1'b1, 8'h03);
		in_valid = 1'b0;
		wait_xfers(2);
		read_status(8'h83);
		wait_scan(7'h7F, 7'h7E, {6'h01, 6'h02, 6'h03});
		wait_scan(7'h7F, 7'h7F, {6'h15, 6'h2A, 6'h3F});
		$display("test remap done");
	endtask

	task automatic power_down();
		int n;
		n = 0;
		power_down_req = 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (row_drivers_on !== 1'b0 && n < 100);
		#1;
		power_down_req = 1'b0;
		chk(link_ready, 0);
		chk(i_oled_bus_if.panel_supply_on, 1);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (i_oled_bus_if.panel_supply_on !== 1'b0 && n < 100);
		chk(logic_supply_on, 1);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (logic_supply_on !== 1'b0 && n < 200);
		chk(n >= OFF && n < OFF + 5, 1);
		#1;
		$display("test power_down done");
	endtask

	task automatic fill_fifo();
		int n;
		refused = 0;
		for (int i = 0; i < 12; i++) begin
			push(1'b1, 8'(i));
		end
		in_valid = 1'b0;
		chk(refused > 0, 1);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (in_ready !== 1'b1 && n < 200);
		chk(in_ready, 1);
		#1;
		$display("test fill_fifo done");
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Clock, watchdog and main sequence
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 90000) begin
			err_count++;
			report_and_stop();
		end
	end

	initial begin
		rstn = 1'b0;
		mode_sel = 1'b0;
		power_up_req = 1'b0;
		power_down_req = 1'b0;
		in_valid = 1'b0;
		in_is_data = 1'b0;
		in_byte = 8'h00;
		rd_req = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		rstn = 1'b1;
		power_up(oled_port_pkg::MODE_INTEL);
		write_pixels();
		remap();
		power_down();
		power_up(oled_port_pkg::MODE_MOTO);
		fill_fifo();
		report_and_stop();
	end
endmodule
